//--- verilog/rmd_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmd_params.svh"

module rmd_exec
	import rmd_pkg::*;
#(
	parameter int TICK_CYCLES = `RMD_SERVO_TICK_NS / `RMD_CLK_PERIOD_NS,
	parameter int PBUF_AW = 10
)
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// avalon-mm register slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// executor command port
	input wire logic cmd_valid,
	input wire rmd_pkg::rmd_cmd_s cmd,
	output logic cmd_ready,
	output logic cmd_done,
	output logic [1:0] thread_hold,
	// user data register read port
	output logic ureg_rd_req,
	output logic [15:0] ureg_addr,
	input wire logic ureg_rd_valid,
	input wire logic [31:0] ureg_rd_data,
	// ordinary relative move engine
	output logic mv_valid,
	output rmd_pkg::rmd_move_s mv,
	input wire logic mv_ready,
	// host immediate commands and download
	input wire logic clear_program_buffer,
	input wire logic begin_download,
	input wire logic dl_wr_valid,
	input wire logic [15:0] dl_wr_data,
	output logic dl_active,
	output logic [PBUF_AW-1:0] dl_ptr,
	// program buffer write port
	output logic pbuf_we,
	output logic [PBUF_AW-1:0] pbuf_addr,
	output logic [15:0] pbuf_data
);
	localparam int TW = $clog2(TICK_CYCLES);

	// ==========================================================
	// servo tick divider
	// ==========================================================
	logic [TW-1:0] tick_cnt_r, tick_cnt_nxt; // cycles into the servo cycle
	logic tick; // one-cycle enable per servo cycle

	// free-running divider; the only timing reference of the block
	always_comb
	begin
		tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));
		tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_nxt;
	end

	// ==========================================================
	// avalon slave handshake
	// ==========================================================
	logic ack_r, ack_nxt; // second cycle of a transfer
	logic [31:0] rdata_r, rdata_nxt; // captured read word
	logic wr_delay; // write to the delay counter takes effect
	logic [31:0] delay_r, delay_nxt; // shared tick delay counter
	logic [1:0] hold_r, hold_nxt; // per thread waiting on delay
	rmd_state_e state_r, state_nxt; // command state
	logic clr_busy_r, clr_busy_nxt; // buffer clear sweep running
	logic dl_active_r, dl_active_nxt; // download in progress
	logic [PBUF_AW-1:0] dl_ptr_r, dl_ptr_nxt; // download write pointer
	logic [31:0] status; // live status word

	// one wait state per transfer: the read word is registered first
	always_comb
	begin
		status = '0;
		status[`RMD_ST_STATE_LSB +: 3] = state_r;
		status[`RMD_ST_CLR_BUSY] = clr_busy_r;
		status[`RMD_ST_DL_ACTIVE] = dl_active_r;
		status[`RMD_ST_HOLD_LSB +: 2] = hold_r;
		status[`RMD_ST_PTR_LSB +: PBUF_AW] = dl_ptr_r;
		ack_nxt = (avs_read | avs_write) & ~ack_r;
		rdata_nxt = rdata_r;
		if (avs_read && !ack_r)
		begin
			unique case (avs_address)
				`RMD_ADDR_STATUS: rdata_nxt = status;
				`RMD_ADDR_DELAY: rdata_nxt = delay_r;
				default: rdata_nxt = '0; // unmapped reads as zero
			endcase
		end
		wr_delay = avs_write & ack_r & (avs_address == `RMD_ADDR_DELAY);
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ack_r <= 1'b0;
			rdata_r <= '0;
		end
		else
		begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// command interpreter and shared delay counter
	// ==========================================================
	logic [1:0] idx_r, idx_nxt; // operand word being fetched
	logic [15:0] uaddr_r, uaddr_nxt; // user register address
	rmd_move_s mv_r, mv_nxt; // move request being built
	logic done_r, done_nxt; // completion pulse
	logic take; // command accepted this cycle
	logic is_delay; // accepted command is a delay
	logic [31:0] bus_word; // delay counter after byte lanes

	// delay priority: command load, then bus write, then tick decrement
	always_comb
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		uaddr_nxt = uaddr_r;
		mv_nxt = mv_r;
		done_nxt = 1'b0;
		take = cmd_valid & (state_r == RMD_IDLE);
		is_delay = take & (cmd.opcode == `RMD_OP_DELAY);
		// a waiting thread resumes once the counter has run out
		hold_nxt = (delay_r == '0) ? 2'b00 : hold_r;
		bus_word = delay_r;
		for (int b = 0; b < 4; b++)
		begin
			if (avs_byteenable[b])
				bus_word[8*b +: 8] = avs_writedata[8*b +: 8];
		end
		delay_nxt = delay_r;
		if (is_delay)
		begin
			// one code for both delay flavours; units are host-side only
			// any thread reloads the single counter, last one wins
			if (!cmd.arg0[31])
			begin
				delay_nxt = cmd.arg0;
				// load then wait; set wins over the zero release
				if (cmd.arg0 != '0)
					hold_nxt[cmd.thread2] = 1'b1;
			end
			else
				delay_nxt = 32'(-cmd.arg0);
		end
		else if (wr_delay)
			delay_nxt = bus_word;
		else if (tick && delay_r != '0)
			delay_nxt = delay_r - 32'h0000_0001;
		unique case (state_r)
			RMD_IDLE:
			begin
				if (take)
				begin
					// register moves exist only in thread 1; others ignored
					if (!cmd.thread2 && (cmd.opcode == `RMD_OP_REG_REL_TIMED ||
						cmd.opcode == `RMD_OP_REG_REL_VELOCITY))
					begin
						state_nxt = RMD_FETCH;
						idx_nxt = '0;
						uaddr_nxt = cmd.arg0[15:0]; // starting register N
						mv_nxt.kind = (cmd.opcode == `RMD_OP_REG_REL_TIMED) ?
							RMD_KIND_TIMED : RMD_KIND_VELOCITY;
						mv_nxt.stop_enable = cmd.stop_enable;
						mv_nxt.stop_state = cmd.stop_state;
					end
					else
						state_nxt = RMD_DONE; // delay and unknown codes finish
				end
			end
			RMD_FETCH:
			begin
				// N, N+1, N+2 land in distance, accel, time or velocity
				if (ureg_rd_valid)
				begin
					unique case (idx_r)
						2'd0: mv_nxt.distance = ureg_rd_data;
						2'd1: mv_nxt.accel = ureg_rd_data;
						default: mv_nxt.time_or_vel = ureg_rd_data;
					endcase
					uaddr_nxt = uaddr_r + 16'h0001;
					idx_nxt = idx_r + 2'd1;
					if (idx_r == 2'(`RMD_OPERAND_WORDS - 1))
						state_nxt = RMD_MOVE;
				end
			end
			RMD_MOVE:
			begin
				// the plain move engine does the rest, unchanged
				if (mv_ready)
					state_nxt = RMD_DONE;
			end
			RMD_DONE:
			begin
				done_nxt = 1'b1;
				state_nxt = RMD_IDLE;
			end
			default: state_nxt = RMD_IDLE;
		endcase
	end

	assign cmd_ready = (state_r == RMD_IDLE);
	assign cmd_done = done_r;
	assign thread_hold = hold_r;
	assign ureg_rd_req = (state_r == RMD_FETCH);
	assign ureg_addr = uaddr_r;
	assign mv_valid = (state_r == RMD_MOVE);
	assign mv = mv_r;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= RMD_IDLE;
			idx_r <= '0;
			uaddr_r <= '0;
			mv_r <= '0;
			done_r <= 1'b0;
			delay_r <= `RMD_DELAY_RESET;
			hold_r <= 2'b00;
		end
		else
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			uaddr_r <= uaddr_nxt;
			mv_r <= mv_nxt;
			done_r <= done_nxt;
			delay_r <= delay_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ==========================================================
	// program buffer clear and download pointer
	// ==========================================================
	logic [PBUF_AW-1:0] clr_addr_r, clr_addr_nxt; // sweep address
	logic we_r, we_nxt; // buffer write strobe
	logic [PBUF_AW-1:0] waddr_r, waddr_nxt; // buffer write address
	logic [15:0] wdata_r, wdata_nxt; // buffer write data

	// the sweep writes zeros to every word; the pointer rewinds only after
	always_comb
	begin
		clr_busy_nxt = clr_busy_r;
		clr_addr_nxt = clr_addr_r;
		dl_active_nxt = dl_active_r;
		dl_ptr_nxt = dl_ptr_r;
		we_nxt = 1'b0;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		if (clr_busy_r)
		begin
			we_nxt = 1'b1;
			waddr_nxt = clr_addr_r;
			wdata_nxt = '0;
			clr_addr_nxt = clr_addr_r + 1'b1;
			if (clr_addr_r == '1)
			begin
				clr_busy_nxt = 1'b0;
				dl_ptr_nxt = '0;
			end
		end
		else if (clear_program_buffer)
		begin
			clr_busy_nxt = 1'b1;
			clr_addr_nxt = '0;
			dl_active_nxt = 1'b0;
		end
		else if (begin_download)
			dl_active_nxt = 1'b1;
		else if (dl_active_r && dl_wr_valid)
		begin
			// download words are dropped while a sweep runs
			we_nxt = 1'b1;
			waddr_nxt = dl_ptr_r;
			wdata_nxt = dl_wr_data;
			dl_ptr_nxt = dl_ptr_r + 1'b1;
		end
	end

	assign dl_active = dl_active_r;
	assign dl_ptr = dl_ptr_r;
	assign pbuf_we = we_r;
	assign pbuf_addr = waddr_r;
	assign pbuf_data = wdata_r;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clr_busy_r <= 1'b0;
			clr_addr_r <= '0;
			dl_active_r <= 1'b0;
			dl_ptr_r <= '0;
			we_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= '0;
		end
		else
		begin
			clr_busy_r <= clr_busy_nxt;
			clr_addr_r <= clr_addr_nxt;
			dl_active_r <= dl_active_nxt;
			dl_ptr_r <= dl_ptr_nxt;
			we_r <= we_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
		end
	end
endmodule
`default_nettype wire

//--- verilog/rmd_params.svh
`ifndef RMD_PARAMS_SVH
`define RMD_PARAMS_SVH
// command codes seen on the executor command port
`define RMD_OP_REG_REL_TIMED 8'hEB
`define RMD_OP_REG_REL_VELOCITY 8'hE9
`define RMD_OP_DELAY 8'h8C
// register indexes; byte address is four times the index
`define RMD_IDX_STATUS 0
`define RMD_IDX_DELAY 5
`define RMD_ADDR_STATUS 5'h00
`define RMD_ADDR_DELAY 5'h14
// status field positions
`define RMD_ST_STATE_LSB 0
`define RMD_ST_CLR_BUSY 3
`define RMD_ST_DL_ACTIVE 4
`define RMD_ST_HOLD_LSB 5
`define RMD_ST_PTR_LSB 16
// reset values
`define RMD_DELAY_RESET 32'h0000_0000
// timing
`define RMD_SERVO_TICK_NS 120000
`define RMD_CLK_PERIOD_NS 25
// number of operand words fetched from user registers
`define RMD_OPERAND_WORDS 3
`endif

//--- verilog/rmd_pkg.sv
package rmd_pkg;
	// command interpreter states
	typedef enum logic [2:0] {
		RMD_IDLE = 3'b000,
		RMD_FETCH = 3'b001,
		RMD_MOVE = 3'b010,
		RMD_DONE = 3'b011
	} rmd_state_e;
	// which ordinary relative move the fetched operands feed
	typedef enum logic {
		RMD_KIND_TIMED = 1'b0,
		RMD_KIND_VELOCITY = 1'b1
	} rmd_kind_e;
	// command word group from the program executor
	typedef struct packed {
		logic [7:0] opcode;
		logic thread2;
		logic [31:0] arg0;
		logic [15:0] stop_enable;
		logic [15:0] stop_state;
	} rmd_cmd_s;
	// request handed to the ordinary relative move engine
	typedef struct packed {
		rmd_kind_e kind;
		logic [31:0] distance;
		logic [31:0] accel;
		logic [31:0] time_or_vel;
		logic [15:0] stop_enable;
		logic [15:0] stop_state;
	} rmd_move_s;
endpackage

//--- sim/rmd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// far side: user registers and move engine
module rmd_far_model
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// user register read
	input wire logic ureg_rd_req,
	input wire logic [15:0] ureg_addr,
	output logic ureg_rd_valid,
	output logic [31:0] ureg_rd_data,
	// move handshake, answer delay
	input wire logic mv_valid,
	output logic mv_ready,
	input wire logic [1:0] slow
);
	logic [1:0] cnt_r; // cycles waited so far
	// one valid pulse per word, after slow cycles
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			{cnt_r, ureg_rd_valid} <= 3'h0;
		else if (ureg_rd_req && !ureg_rd_valid && cnt_r >= slow)
			{cnt_r, ureg_rd_valid} <= 3'h1;
		else
			{cnt_r, ureg_rd_valid} <= {(ureg_rd_req | mv_valid) ? cnt_r + 2'h1 : 2'h0, 1'b0};
	// data names its register; scrambled outside the pulse so stale reads show
	assign ureg_rd_data = ureg_rd_valid ? {16'hA5C3, ureg_addr} : {16'h5A3C, ~ureg_addr};
	assign mv_ready = mv_valid && cnt_r >= slow;
endmodule
`default_nettype wire

//--- sim/rmd_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmd_params.svh"
// ==========
// port checks on the interpreter
module rmd_exec_properties
	import rmd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// command port
	input wire logic cmd_valid,
	input wire rmd_pkg::rmd_cmd_s cmd,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic [1:0] thread_hold,
	// fetch and move
	input wire logic ureg_rd_req,
	input wire logic [15:0] ureg_addr,
	input wire logic ureg_rd_valid,
	input wire logic mv_valid,
	input wire rmd_pkg::rmd_move_s mv,
	input wire logic mv_ready,
	// clear and download
	input wire logic clear_program_buffer,
	input wire logic dl_active,
	input wire logic pbuf_we
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic take; // command accepted
	logic xmv; // register move opcode
	logic dly; // delay opcode
	assign take = cmd_valid && cmd_ready;
	assign xmv = cmd.opcode == `RMD_OP_REG_REL_TIMED || cmd.opcode == `RMD_OP_REG_REL_VELOCITY;
	assign dly = take && cmd.opcode == `RMD_OP_DELAY && !cmd.thread2;
	// ==========
	// assertions
	fetch_start_a: assert property (take && xmv && !cmd.thread2 |=>
		ureg_rd_req && ureg_addr == $past(cmd.arg0[15:0])) else $error("bad first operand");
	fetch_order_a: assert property (ureg_rd_req && ureg_rd_valid |=>
		!ureg_rd_req || ureg_addr == $past(ureg_addr) + 16'h1) else $error("operand skipped");
	move_steady_a: assert property (mv_valid && !mv_ready |=>
		mv_valid && $stable(mv)) else $error("move request dropped");
	thread_two_a: assert property (take && xmv && cmd.thread2 |=>
		!ureg_rd_req ##1 cmd_done) else $error("thread two move ran");
	clear_stops_a: assert property (clear_program_buffer && dl_active |=>
		!dl_active) else $error("download kept on");
	sweep_len_a: assert property (clear_program_buffer && dl_active |=>
		##1 pbuf_we [*8] ##1 pbuf_we [*8] ##1 !pbuf_we) else $error("sweep length wrong");
	delay_wait_a: assert property (dly && $signed(cmd.arg0) > 0 |=>
		##1 cmd_done && thread_hold[0]) else $error("no delay hold");
	delay_go_a: assert property (dly && $signed(cmd.arg0) < 0 |=>
		##1 cmd_done && !thread_hold[0]) else $error("negative delay held");
	// main scenarios reached
	cover property (mv_valid && mv_ready);
	cover property (clear_program_buffer && dl_active);
	cover property (dly);
endmodule
bind rmd_exec rmd_exec_properties u_props (.*);
`default_nettype wire

//--- sim/rmd_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmd_params.svh"
// ==========
// bench: register moves, delays, clear
module rmd_exec_tb;
	import rmd_pkg::*;
	localparam int TICKS = 8; // short servo tick
	logic clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, cmd_valid = 1'b0;
	logic clear_program_buffer = 1'b0, begin_download = 1'b0, dl_wr_valid = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, ureg_rd_data, rd, v;
	logic [15:0] dl_wr_data = 16'h0, ureg_addr, pbuf_data, n;
	logic [1:0] slow = 2'h0, thread_hold; // slow: far side delay
	logic [3:0] dl_ptr, pbuf_addr;
	logic avs_waitrequest, cmd_ready, cmd_done, ureg_rd_req, ureg_rd_valid;
	logic mv_valid, mv_ready, dl_active, pbuf_we;
	rmd_cmd_s cmd = '0;
	rmd_move_s mv, mv_got;
	integer err_count = 0, n_compared = 0, seed = 47493, mv_n = 0, we_n = 0, held = 0, i;
	always #12.5 clk = ~clk;
	rmd_exec #(.TICK_CYCLES(TICKS), .PBUF_AW(4)) dut (.*);
	rmd_far_model far (.*);
	// tally handoffs, buffer writes and held cycles
	always @(posedge clk)
	begin
		if (mv_valid && mv_ready)
			mv_got <= mv;
		mv_n <= mv_n + (mv_valid && mv_ready);
		we_n <= we_n + pbuf_we;
		held <= held + thread_hold[0];
	end
	// ==========
	// tasks
	function automatic logic [31:0] exp_word(input logic [15:0] a);
		return {16'hA5C3, a};
	endfunction
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		{avs_address, avs_write, avs_read, avs_writedata} <= {a, wr, !wr, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
	endtask
	// done is a one-cycle pulse, so every edge is polled
	task automatic issue(input logic [7:0] op, input logic t2, input logic [31:0] a);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= {op, t2, a, 16'h00F0, 16'h0030};
		@(posedge clk);
		while (cmd_ready !== 1'b1) @(posedge clk);
		cmd_valid <= 1'b0;
		while (cmd_done !== 1'b1) @(posedge clk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ==========
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		bus(1'b0, `RMD_ADDR_DELAY, 32'h0);
		chk("delay reset", `RMD_DELAY_RESET, rd);
		bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
		bus(1'b0, 5'h1C, 32'h0);
		chk("unmapped", 32'h0, rd);
		for (i = 0; i < 6; i++)
		begin
			n = i ? 16'($random(seed)) : 16'hFFFE; // first case wraps the index
			slow <= 2'($random(seed));
			issue(i[0] ? `RMD_OP_REG_REL_VELOCITY : `RMD_OP_REG_REL_TIMED, 1'b0, {16'h0, n});
			chk("move kind", {31'h0, i[0]}, {31'h0, mv_got.kind});
			chk("distance", exp_word(n), mv_got.distance);
			chk("accel", exp_word(n + 16'h1), mv_got.accel);
			chk("time or vel", exp_word(n + 16'h2), mv_got.time_or_vel);
			chk("stop enable", 32'h00F0, {16'h0, mv_got.stop_enable});
			chk("stop state", 32'h0030, {16'h0, mv_got.stop_state});
		end
		v = mv_n;
		issue(`RMD_OP_REG_REL_TIMED, 1'b1, 32'h1E);
		chk("thread two move", v, mv_n);
		v = held;
		issue(`RMD_OP_DELAY, 1'b0, 32'h3);
		chk("hold set", 32'h1, {31'h0, thread_hold[0]});
		while (thread_hold[0] === 1'b1) @(posedge clk);
		chk("held span", 32'h1, {31'h0, held - v >= 2 * TICKS && held - v <= 3 * TICKS + 3});
		bus(1'b0, `RMD_ADDR_DELAY, 32'h0);
		chk("count at zero", 32'h0, rd);
		// only the low lane is enabled, so the upper lanes must stay clear
		avs_byteenable <= 4'h1;
		bus(1'b1, `RMD_ADDR_DELAY, 32'hFFFF_FF12);
		avs_byteenable <= 4'hF;
		bus(1'b0, `RMD_ADDR_DELAY, 32'h0);
		chk("lane write", 32'h1, {31'h0, rd == 32'h12 || rd == 32'h11});
		issue(`RMD_OP_DELAY, 1'b1, 32'd100);
		chk("thread two hold", 32'h1, {31'h0, thread_hold[1]});
		issue(`RMD_OP_DELAY, 1'b0, -32'sd7);
		chk("no wait", 32'h0, {31'h0, thread_hold[0]});
		bus(1'b0, `RMD_ADDR_DELAY, 32'h0);
		chk("magnitude", 32'h1, {31'h0, rd == 32'd7 || rd == 32'd6});
		repeat (8 * TICKS) @(posedge clk);
		chk("shared release", 32'h0, {30'h0, thread_hold});
		@(posedge clk);
		begin_download <= 1'b1;
		@(posedge clk);
		begin_download <= 1'b0;
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk);
			v = $random(seed);
			{dl_wr_valid, dl_wr_data} <= {1'b1, v[15:0]};
			@(posedge clk);
			dl_wr_valid <= 1'b0;
		end
		repeat (2) @(posedge clk);
		chk("download ptr", 32'h3, {28'h0, dl_ptr});
		chk("last word addr", 32'h2, {28'h0, pbuf_addr});
		chk("last word data", {16'h0, v[15:0]}, {16'h0, pbuf_data});
		// status: download active, pointer three, nothing else pending
		bus(1'b0, `RMD_ADDR_STATUS, 32'h0);
		chk("status", 32'h0003_0010, rd);
		v = we_n;
		clear_program_buffer <= 1'b1;
		@(posedge clk);
		clear_program_buffer <= 1'b0;
		repeat (24) @(posedge clk);
		chk("cleared words", 32'd16, we_n - v);
		chk("sweep data", 32'h0, {16'h0, pbuf_data});
		chk("sweep end addr", 32'hF, {28'h0, pbuf_addr});
		chk("ptr rewound", 32'h0, {28'h0, dl_ptr});
		chk("download ended", 32'h0, {31'h0, dl_active});
		results();
	end
	// the tests need under two thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		results();
	end
endmodule
`default_nettype wire
